/* hw/lcd_pkg.sv */
// Operation
// - Clear blanks RAM, zeroes counter, forces increment.
// - Home zeroes counter and undoes display shift.
// - Entry mode stores direction; counter steps accordingly.
// - Pattern RAM accesses step counter the same way.
// - Display RAM writes shift display when enabled.
// - Display bit blanks or shows, RAM kept.
// - Cursor bit shows cursor, direction kept.
// - Blink alternates cursor cell with all dots.
// - Shift command moves cursor or whole display.
// - Display shift keeps counter, touches no data.
// - Two-line cursor wraps past position 40.
// - Bus width selects 8-bit or two 4-bit halves.
// - Line count selects one or two lines.
// - Font bit selects 5x8 or 5x11 dots.
// - Pattern address command loads six counter bits.
// - Codes 00-0F index eight user patterns.
// - Busy flag high in bit 7 while executing.
// - Each RAM access steps counter by one.
// - Select bit marks instruction or RAM data.
// - Status read returns busy and counter.
package lcd_pkg;

  // ==========================================================
  // Register map, byte addresses on the register bus.
  localparam logic [3:0] OFS_CMD  = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;

  // ==========================================================
  // Addresses and codes.
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam logic [6:0] AC_HOME    = 7'h00;
  localparam logic [6:0] LINE1_END  = 7'h27;
  localparam logic [6:0] LINE2_BEG  = 7'h40;
  localparam logic [6:0] LINE2_END  = 7'h67;
  localparam logic [6:0] ONE_END    = 7'h4F;
  localparam logic [6:0] LINE_LEN   = 7'h28;
  localparam logic [6:0] ALL_LEN    = 7'h50;
  localparam logic [5:0] PAT_END    = 6'h3F;

  // ==========================================================
  // Command field positions.
  localparam int EM_INC = 1;
  localparam int EM_SH  = 0;
  localparam int DC_DSP = 2;
  localparam int DC_CUR = 1;
  localparam int DC_BLK = 0;
  localparam int SH_DSP = 3;
  localparam int SH_RGT = 2;
  localparam int FS_BUS = 4;
  localparam int FS_LIN = 3;
  localparam int FS_FNT = 2;

  // ==========================================================
  // Execution times.
  localparam int CLK_MHZ      = 40;
  localparam int EXEC_CMD_NS  = 39000;
  localparam int EXEC_DATA_NS = 43000;
  localparam int EXEC_LONG_NS = 1530000;
  localparam int EXEC_CMD_CYC  = (EXEC_CMD_NS * CLK_MHZ + 999) / 1000;
  localparam int EXEC_DATA_CYC = (EXEC_DATA_NS * CLK_MHZ + 999) / 1000;
  localparam int EXEC_LONG_CYC = (EXEC_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_CYC     = 20000000;

  // ==========================================================
  // Types.
  typedef enum logic [7:0] {
    CMD_CLEAR = 8'h01, CMD_HOME = 8'h02, CMD_ENTRY = 8'h04, CMD_DISP = 8'h08,
    CMD_SHIFT = 8'h10, CMD_FUNC = 8'h20, CMD_PAT  = 8'h40, CMD_OTHER = 8'h80
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_FILL = 3'h2, ST_WAIT = 3'h4
  } state_t;

  typedef struct packed {
    logic font_large;
    logic two_line;
    logic bus8;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic incr;
    logic shift_en;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{font_large: 1'b0, two_line: 1'b0, bus8: 1'b1,
                                   disp_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0,
                                   incr: 1'b1, shift_en: 1'b0};

endpackage

/* hw/char_lcd_instruction_decoder.sv */
`timescale 1ns/100ps
module char_lcd_instruction_decoder #(
  parameter int LONG_CYC  = lcd_pkg::EXEC_LONG_CYC,
  parameter int BLINK_CYC = lcd_pkg::BLINK_CYC
) (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // User pattern lookup.
  input  wire logic [7:0]  glyph_code_i,
  input  wire logic [2:0]  glyph_row_i,
  output logic      [4:0]  glyph_dots_o,
  output logic             glyph_user_o,
  // Display state.
  output logic             busy_flag_o,
  output logic      [6:0]  address_counter_o,
  output logic      [6:0]  shift_offset_o,
  output logic             display_on_o,
  output logic             cursor_on_o,
  output logic             cursor_all_dots_o,
  output logic             two_line_o,
  output logic             font_large_o,
  output logic             bus8_o
);

  // ==========================================================
  // Helper functions.

  // Decodes a command word by its highest set bit.
  function automatic lcd_pkg::cmd_t decode(input logic [7:0] b);
    casez (b)
      8'b1???????: decode = lcd_pkg::CMD_OTHER;
      8'b01??????: decode = lcd_pkg::CMD_PAT;
      8'b001?????: decode = lcd_pkg::CMD_FUNC;
      8'b0001????: decode = lcd_pkg::CMD_SHIFT;
      8'b00001???: decode = lcd_pkg::CMD_DISP;
      8'b000001??: decode = lcd_pkg::CMD_ENTRY;
      8'b0000001?: decode = lcd_pkg::CMD_HOME;
      8'b00000001: decode = lcd_pkg::CMD_CLEAR;
      default:     decode = lcd_pkg::CMD_OTHER;
    endcase
  endfunction

  // Steps the address counter one place, wrapping per RAM and line mode.
  function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up,
                                         input logic two, input logic pat);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (pat) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (up && a == lcd_pkg::LINE1_END) r = lcd_pkg::LINE2_BEG;
      if (up && a == lcd_pkg::LINE2_END) r = lcd_pkg::AC_HOME;
      if (!up && a == lcd_pkg::LINE2_BEG) r = lcd_pkg::LINE1_END;
      if (!up && a == lcd_pkg::AC_HOME) r = lcd_pkg::LINE2_END;
    end else begin
      if (up && a == lcd_pkg::ONE_END) r = lcd_pkg::AC_HOME;
      if (!up && a == lcd_pkg::AC_HOME) r = lcd_pkg::ONE_END;
    end
    step_ac = r;
  endfunction

  // Moves the display offset one place within the line length.
  function automatic logic [6:0] step_shift(input logic [6:0] o, input logic left,
                                            input logic two);
    logic [6:0] len;
    len = two ? lcd_pkg::LINE_LEN : lcd_pkg::ALL_LEN;
    if (left) step_shift = (o >= len - 7'h01) ? 7'h00 : o + 7'h01;
    else      step_shift = (o == 7'h00 || o >= len) ? len - 7'h01 : o - 7'h01;
  endfunction

  // Maps a display address onto a storage index.
  function automatic logic [6:0] ram_index(input logic [6:0] a, input logic two);
    if (two && a >= lcd_pkg::LINE2_BEG) ram_index = a - lcd_pkg::LINE2_BEG + lcd_pkg::LINE_LEN;
    else ram_index = a;
  endfunction

  // ==========================================================
  // State.
  lcd_pkg::state_t state_r;
  lcd_pkg::ctrl_t  ctrl_r;
  logic [6:0]      ac_r;
  logic [6:0]      shift_r;
  logic            pat_sel_r;
  logic [25:0]     wait_r;
  logic [6:0]      fill_r;
  logic            ack_r;
  logic            half_r;
  logic [3:0]      hi_nib_r;
  logic [24:0]     blink_cnt_r;
  logic            blink_ph_r;
  logic [7:0]      disp_ram_r [80];
  logic [7:0]      pat_ram_r [64];

  logic            busy;
  logic            take;
  logic            wr_take;
  logic            rd_take;
  logic            byte_go;
  logic            is_data;
  logic            data_wr;
  logic            data_rd;
  logic            cmd_go;
  logic [7:0]      in_byte;
  lcd_pkg::cmd_t   cmd;
  logic [6:0]      idx;
  logic [7:0]      ram_q;

  // ==========================================================
  // Bus handshake: every access is answered one cycle after it rises.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign take    = (avs_read_i | avs_write_i) & ack_r;
  assign wr_take = take & avs_write_i;
  assign rd_take = take & avs_read_i;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) ack_r <= 1'b0;
    else         ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
  end

  // ==========================================================
  // Byte assembly; 4-bit mode takes the high half, then the low half.
  assign is_data = avs_address_i == lcd_pkg::OFS_DATA;
  assign in_byte = ctrl_r.bus8 ? avs_writedata_i[7:0] : {hi_nib_r, avs_writedata_i[3:0]};
  assign byte_go = wr_take & avs_byteenable_i[0] & ~busy & (ctrl_r.bus8 | half_r) &
                   (is_data | avs_address_i == lcd_pkg::OFS_CMD);
  assign data_wr = byte_go & is_data;
  assign cmd_go  = byte_go & ~is_data;
  assign data_rd = rd_take & is_data & ~busy;
  assign cmd     = decode(in_byte);
  assign idx     = ram_index(ac_r, ctrl_r.two_line);

  // Nibble pairing for the narrow bus.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_r   <= 1'b0;
      hi_nib_r <= 4'h0;
    end else if (ctrl_r.bus8) begin
      half_r <= 1'b0;
    end else if (wr_take && avs_byteenable_i[0] && !busy &&
                 (is_data || avs_address_i == lcd_pkg::OFS_CMD)) begin
      half_r   <= ~half_r;
      hi_nib_r <= avs_writedata_i[3:0];
    end
  end

  // ==========================================================
  // Execution sequencer; reset starts with the blanking fill.
  assign busy = state_r != lcd_pkg::ST_IDLE;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= lcd_pkg::ST_FILL;
      fill_r  <= 7'h00;
      wait_r  <= 26'h0000000;
    end else begin
      unique case (state_r)
        lcd_pkg::ST_IDLE: begin
          fill_r <= 7'h00;
          if (cmd_go && cmd == lcd_pkg::CMD_CLEAR) begin
            state_r <= lcd_pkg::ST_FILL;
          end else if (cmd_go && cmd == lcd_pkg::CMD_HOME) begin
            state_r <= lcd_pkg::ST_WAIT;
            wait_r  <= 26'(LONG_CYC - 1);
          end else if (cmd_go) begin
            state_r <= lcd_pkg::ST_WAIT;
            wait_r  <= 26'(lcd_pkg::EXEC_CMD_CYC - 1);
          end else if (data_wr || data_rd) begin
            state_r <= lcd_pkg::ST_WAIT;
            wait_r  <= 26'(lcd_pkg::EXEC_DATA_CYC - 1);
          end
        end
        lcd_pkg::ST_FILL: begin
          fill_r <= fill_r + 7'h01;
          if (fill_r == lcd_pkg::ALL_LEN - 7'h01) begin
            state_r <= lcd_pkg::ST_WAIT;
            wait_r  <= 26'(LONG_CYC - 1) - 26'(lcd_pkg::ALL_LEN);
          end
        end
        lcd_pkg::ST_WAIT: begin
          wait_r <= wait_r - 26'h0000001;
          if (wait_r == 26'h0000000) state_r <= lcd_pkg::ST_IDLE;
        end
        default: state_r <= lcd_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Address counter, target RAM and display shift.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ac_r      <= lcd_pkg::AC_HOME;
      shift_r   <= 7'h00;
      pat_sel_r <= 1'b0;
    end else if (cmd_go) begin
      unique case (cmd)
        lcd_pkg::CMD_CLEAR, lcd_pkg::CMD_HOME: begin
          ac_r      <= lcd_pkg::AC_HOME;
          shift_r   <= 7'h00;
          pat_sel_r <= 1'b0;
        end
        lcd_pkg::CMD_SHIFT: begin
          if (in_byte[lcd_pkg::SH_DSP])
            shift_r <= step_shift(shift_r, ~in_byte[lcd_pkg::SH_RGT], ctrl_r.two_line);
          else
            ac_r <= step_ac(ac_r, in_byte[lcd_pkg::SH_RGT], ctrl_r.two_line,
                            pat_sel_r);
        end
        lcd_pkg::CMD_PAT: begin
          ac_r      <= {1'b0, in_byte[5:0]};
          pat_sel_r <= 1'b1;
        end
        default: ;
      endcase
    end else if (data_wr || data_rd) begin
      ac_r <= step_ac(ac_r, ctrl_r.incr, ctrl_r.two_line, pat_sel_r);
      if (data_wr && !pat_sel_r && ctrl_r.shift_en)
        shift_r <= step_shift(shift_r, ctrl_r.incr, ctrl_r.two_line);
    end
  end

  // ==========================================================
  // Control bits set by the mode commands.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= lcd_pkg::CTRL_RESET;
    end else if (cmd_go) begin
      unique case (cmd)
        lcd_pkg::CMD_CLEAR: ctrl_r.incr <= 1'b1;
        lcd_pkg::CMD_ENTRY: begin
          ctrl_r.incr     <= in_byte[lcd_pkg::EM_INC];
          ctrl_r.shift_en <= in_byte[lcd_pkg::EM_SH];
        end
        lcd_pkg::CMD_DISP: begin
          ctrl_r.disp_on   <= in_byte[lcd_pkg::DC_DSP];
          ctrl_r.cursor_on <= in_byte[lcd_pkg::DC_CUR];
          ctrl_r.blink_on  <= in_byte[lcd_pkg::DC_BLK];
        end
        lcd_pkg::CMD_FUNC: begin
          ctrl_r.bus8       <= in_byte[lcd_pkg::FS_BUS];
          ctrl_r.two_line   <= in_byte[lcd_pkg::FS_LIN];
          ctrl_r.font_large <= in_byte[lcd_pkg::FS_FNT];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Character storage; clear fills blanks one cell a cycle.
  always_ff @(posedge mclk_i) begin
    if (state_r == lcd_pkg::ST_FILL)
      disp_ram_r[fill_r] <= lcd_pkg::BLANK_CODE;
    else if (data_wr && pat_sel_r)
      pat_ram_r[ac_r[5:0]] <= in_byte;
    else if (data_wr && idx < lcd_pkg::ALL_LEN)
      disp_ram_r[idx] <= in_byte;
  end

  assign ram_q = pat_sel_r ? pat_ram_r[ac_r[5:0]] :
                 (idx < lcd_pkg::ALL_LEN) ? disp_ram_r[idx] : 8'h00;

  // ==========================================================
  // Read data register, loaded in the first cycle of a read so that it
  // already stands at the edge where waitrequest is seen low.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_r) begin
      unique case (avs_address_i)
        lcd_pkg::OFS_CMD:  avs_readdata_o <= {24'h000000, busy, ac_r};
        lcd_pkg::OFS_DATA: avs_readdata_o <= {24'h000000, ram_q};
        lcd_pkg::OFS_CTRL: avs_readdata_o <= {16'h0000, shift_r, pat_sel_r, ctrl_r};
        default:           avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // User pattern lookup for codes with zero upper nibble.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      glyph_dots_o <= 5'h00;
      glyph_user_o <= 1'b0;
    end else begin
      glyph_user_o <= glyph_code_i[7:4] == 4'h0;
      glyph_dots_o <= pat_ram_r[{glyph_code_i[2:0], glyph_row_i}][4:0];
    end
  end

  // ==========================================================
  // Blink phase divider.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blink_cnt_r <= 25'h0000000;
      blink_ph_r  <= 1'b0;
    end else if (blink_cnt_r == 25'(BLINK_CYC - 1)) begin
      blink_cnt_r <= 25'h0000000;
      blink_ph_r  <= ~blink_ph_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 25'h0000001;
    end
  end

  // Display outputs.
  assign busy_flag_o       = busy;
  assign address_counter_o = ac_r;
  assign shift_offset_o    = shift_r;
  assign display_on_o      = ctrl_r.disp_on;
  assign cursor_on_o       = ctrl_r.disp_on & ctrl_r.cursor_on;
  assign cursor_all_dots_o = ctrl_r.disp_on & ctrl_r.blink_on & blink_ph_r;
  assign two_line_o        = ctrl_r.two_line;
  assign font_large_o      = ctrl_r.font_large;
  assign bus8_o            = ctrl_r.bus8;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_clear_go;
    cmd_go && cmd == lcd_pkg::CMD_CLEAR;
  endsequence

  sequence s_fill_run;
    state_r == lcd_pkg::ST_FILL [*8];
  endsequence

  chk_clear_sequence: assert property (s_clear_go |=> s_fill_run ##0 ac_r == 7'h00)
    else $error("clear did not start fill with counter at home");
  chk_clear_incr: assert property (s_clear_go |=> ctrl_r.incr)
    else $error("clear did not force increment");
  chk_home_shift: assert property (cmd_go && cmd == lcd_pkg::CMD_HOME
                                   |=> shift_r == 7'h00 && ac_r == 7'h00 && busy)
    else $error("home did not restore position");
  chk_step_up: assert property (data_wr && ctrl_r.incr && !pat_sel_r && !ctrl_r.two_line
                                && ac_r < lcd_pkg::ONE_END
                                |=> ac_r == $past(ac_r) + 7'h01)
    else $error("counter did not step up by one");
  chk_read_no_shift: assert property (data_rd |=> $stable(shift_r))
    else $error("display shifted on a read");
  chk_shift_keeps_ac: assert property (cmd_go && cmd == lcd_pkg::CMD_SHIFT
                                       && in_byte[lcd_pkg::SH_DSP] |=> $stable(ac_r))
    else $error("display shift changed counter");
  chk_line_wrap: assert property (cmd_go && cmd == lcd_pkg::CMD_SHIFT && !pat_sel_r
                                  && !in_byte[lcd_pkg::SH_DSP] && in_byte[lcd_pkg::SH_RGT]
                                  && ctrl_r.two_line && ac_r == lcd_pkg::LINE1_END
                                  |=> ac_r == lcd_pkg::LINE2_BEG)
    else $error("cursor did not wrap to second line");
  // Counts busy cycles after a short command, since the span is too long for a delay range.
  logic        span_arm_r;
  logic [10:0] span_cnt_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      span_arm_r <= 1'b0;
      span_cnt_r <= 11'h000;
    end else if (cmd_go && cmd == lcd_pkg::CMD_DISP) begin
      span_arm_r <= 1'b1;
      span_cnt_r <= 11'h000;
    end else if (!busy) begin
      span_arm_r <= 1'b0;
    end else if (span_arm_r) begin
      span_cnt_r <= span_cnt_r + 11'h001;
    end
  end

  chk_busy_span: assert property (cmd_go && cmd == lcd_pkg::CMD_DISP
                                  |=> busy [*8])
    else $error("busy span wrong for short command");
  chk_busy_end: assert property (span_arm_r |-> (busy ? span_cnt_r < 11'(lcd_pkg::EXEC_CMD_CYC)
                                 : span_cnt_r == 11'(lcd_pkg::EXEC_CMD_CYC)))
    else $error("busy did not fall after the short command time");
  chk_wrap_back: assert property (cmd_go && cmd == lcd_pkg::CMD_SHIFT && !pat_sel_r
                                  && !in_byte[lcd_pkg::SH_DSP] && !in_byte[lcd_pkg::SH_RGT]
                                  && ctrl_r.two_line && ac_r == lcd_pkg::AC_HOME
                                  |=> ac_r == lcd_pkg::LINE2_END)
    else $error("cursor did not wrap back to second line end");
  chk_pat_load: assert property (cmd_go && cmd == lcd_pkg::CMD_PAT
                                 |=> pat_sel_r && ac_r == {1'b0, $past(in_byte[5:0])})
    else $error("pattern address not loaded");
  chk_blink_off: assert property (!ctrl_r.blink_on |-> !cursor_all_dots_o)
    else $error("blink without blink bit");

endmodule // char_lcd_instruction_decoder

/* testbench/lcd_host_model.sv */
`timescale 1ns/100ps
// ====================================
// Host processor: Avalon-MM master that polls the busy flag.
module lcd_host_model (
  // Clock.
  input  wire logic        mclk_i,
  // Avalon-MM master side.
  output logic      [3:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i
);
  logic nib4 = 1'b0;
  int   tmo  = 0;

  // The bus starts idle.
  initial begin
    address_o   = 4'h0;
    read_o      = 1'b0;
    write_o     = 1'b0;
    writedata_o = 32'h0;
  end

  // One transfer, held until waitrequest is seen low.
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    address_o   <= a;
    writedata_o <= {24'h0, d};
    write_o     <= wr;
    read_o      <= ~wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitrequest_i !== 1'b0 && n < 100);
    if (n >= 100) tmo++;
    q = readdata_i;
    read_o      <= 1'b0;
    write_o     <= 1'b0;
    writedata_o <= ~writedata_o;
  endtask

  // Polls status until idle, then leaves a margin before the next request.
  task automatic wait_idle();
    logic [31:0] q;
    q = 32'h80;
    while (q[7] !== 1'b0) xfer(1'b0, lcd_pkg::OFS_CMD, 8'h00, q);
    repeat (4) @(posedge mclk_i);
  endtask

  // Sends one byte as an instruction or as data, whole or as two halves.
  task automatic send(input logic rs, input logic [7:0] d);
    logic [31:0] q;
    logic [3:0]  a;
    a = rs ? lcd_pkg::OFS_DATA : lcd_pkg::OFS_CMD;
    wait_idle();
    if (nib4) begin
      xfer(1'b1, a, {4'h0, d[7:4]}, q);
      xfer(1'b1, a, {4'h0, d[3:0]}, q);
    end else begin
      xfer(1'b1, a, d, q);
    end
  endtask
endmodule // lcd_host_model

/* testbench/tb.sv */
`timescale 1ns/100ps
// ====================================
// Self-checking bench for the display instruction decoder.
module tb;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  adr;
  logic        rd, wr, wreq;
  logic [31:0] wd, rdat, q;
  logic [7:0]  gcode = 8'h00;
  logic [2:0]  grow  = 3'h0;
  logic [4:0]  gdots;
  logic        guser, busy, don, con, cdots, two, fnt, b8;
  logic [6:0]  ac, sh, s;
  logic [1:0]  seen;
  int          error_cnt = 0;
  int          n_checks  = 0;

  // Design under test with short long-command and blink counts.
  char_lcd_instruction_decoder #(.LONG_CYC(200), .BLINK_CYC(16)) DUT (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .glyph_code_i(gcode),
    .glyph_row_i(grow), .glyph_dots_o(gdots), .glyph_user_o(guser),
    .busy_flag_o(busy), .address_counter_o(ac), .shift_offset_o(sh),
    .display_on_o(don), .cursor_on_o(con), .cursor_all_dots_o(cdots),
    .two_line_o(two), .font_large_o(fnt), .bus8_o(b8));

  // Host processor on the register bus.
  lcd_host_model HOST (.mclk_i(mclk_i), .address_o(adr), .read_o(rd), .write_o(wr),
    .writedata_o(wd), .readdata_i(rdat), .waitrequest_i(wreq));

  // 40 MHz clock.
  initial forever #12.5 mclk_i = ~mclk_i;

  // ====================================
  // Shared helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] d);
    HOST.send(1'b0, d);
    HOST.wait_idle();
  endtask

  task automatic dat(input logic [7:0] d);
    HOST.send(1'b1, d);
    HOST.wait_idle();
  endtask

  task automatic rdreg(input logic [3:0] a);
    HOST.xfer(1'b0, a, 8'h00, q);
  endtask

  task automatic glyph(input logic [7:0] c, input logic [2:0] r);
    @(posedge mclk_i);
    gcode <= c;
    grow  <= r;
    repeat (2) @(negedge mclk_i);
  endtask

  // ====================================
  // Scenarios.
  task automatic t_reset();
    @(negedge mclk_i);
    chk(busy, 1'b1);
    HOST.wait_idle();
    chk({b8, two, fnt, don}, 4'b1000);
    rdreg(lcd_pkg::OFS_CTRL);
    chk(q[7:0], 8'h22);
    rdreg(4'hC);
    chk(q, 32'h0);
  endtask

  task automatic t_data();
    HOST.send(1'b0, 8'h06);
    rdreg(lcd_pkg::OFS_CMD);
    chk(q[7], 1'b1);
    HOST.wait_idle();
    dat(8'h41);
    dat(8'h42);
    rdreg(lcd_pkg::OFS_CMD);
    chk(q[7:0], 8'h02);
    cmd(8'h04);
    dat(8'h43);
    chk(ac, 7'h01);
    rdreg(lcd_pkg::OFS_DATA);
    chk(q[7:0], 8'h42);
  endtask

  task automatic t_clear();
    cmd(8'h01);
    chk({sh, ac}, 14'h0);
    rdreg(lcd_pkg::OFS_CTRL);
    chk(q[1], 1'b1);
    rdreg(lcd_pkg::OFS_DATA);
    chk(q[7:0], lcd_pkg::BLANK_CODE);
  endtask

  task automatic t_shift();
    cmd(8'h03);
    cmd(8'h17);
    chk(ac, 7'h01);
    cmd(8'h10);
    chk(ac, 7'h00);
    cmd(8'h18);
    s = sh;
    chk({ac, s !== 7'h00}, 8'h01);
    cmd(8'h1C);
    chk(sh, 7'h00);
    cmd(8'h18);
    cmd(8'h03);
    chk({sh, ac}, 14'h0);
    cmd(8'h07);
    dat(8'h44);
    chk(sh, s);
    cmd(8'h06);
    dat(8'h45);
    chk({sh, ac}, {s, 7'h02});
  endtask

  task automatic t_func();
    cmd(8'h3F);
    chk({b8, two, fnt}, 3'b111);
    cmd(8'h20);
    chk({b8, two, fnt}, 3'b000);
    HOST.nib4 = 1'b1;
    cmd(8'h0C);
    chk({don, con}, 2'b10);
    cmd(8'h38);
    HOST.nib4 = 1'b0;
    chk({b8, two}, 2'b11);
  endtask

  task automatic t_display();
    cmd(8'h0F);
    chk({don, con}, 2'b11);
    seen = 2'b00;
    repeat (40) begin
      @(negedge mclk_i);
      if (cdots === 1'b1) seen[1] = 1'b1;
      if (cdots === 1'b0) seen[0] = 1'b1;
    end
    chk(seen, 2'b11);
    cmd(8'h0C);
    seen = 2'b00;
    repeat (40) begin
      @(negedge mclk_i);
      if (cdots !== 1'b0) seen[1] = 1'b1;
    end
    rdreg(lcd_pkg::OFS_CTRL);
    chk({seen, con, q[1]}, 4'b0001);
    cmd(8'h08);
    chk(don, 1'b0);
  endtask

  task automatic t_pattern();
    cmd(8'h48);
    chk(ac, 7'h08);
    dat(8'hE5);
    dat(8'h0A);
    chk(ac, 7'h0A);
    cmd(8'h04);
    dat(8'h1B);
    chk(ac, 7'h09);
    glyph(8'h09, 3'h0);
    chk({guser, gdots}, 6'h25);
    glyph(8'h01, 3'h2);
    chk({guser, gdots}, 6'h3B);
    glyph(8'h11, 3'h1);
    chk(guser, 1'b0);
  endtask

  // Cursor wraps between home and the second line end in two-line mode.
  task automatic t_wrap();
    cmd(8'h02);
    cmd(8'h10);
    chk(ac, lcd_pkg::LINE2_END);
    cmd(8'h14);
    chk(ac, lcd_pkg::AC_HOME);
  endtask

  // ====================================
  // Verdict and end of run.
  task automatic print_verdict();
    error_cnt += HOST.tmo;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence after an 8-cycle reset.
  initial begin
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_data();
    t_clear();
    t_shift();
    t_func();
    t_display();
    t_pattern();
    t_wrap();
    print_verdict();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge mclk_i);
    error_cnt++;
    print_verdict();
  end
endmodule // tb
